// >>> hdl/sarc_pkg.sv
package sarc_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] MODE_OFFSET = 8'h00;
    localparam logic [7:0] RESULT_OFFSET = 8'h04;
    localparam logic [7:0] RESULT_HIGH_OFFSET = 8'h08;
    localparam logic [7:0] CHANNEL_OFFSET = 8'h0C;
    localparam logic [7:0] THR_MODE_OFFSET = 8'h10;
    localparam logic [7:0] THR_VALUE_OFFSET = 8'h14;
    localparam logic [7:0] STATUS_OFFSET = 8'h18;

    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [2:0] CHANNEL_RESET = 3'h0;
    localparam logic [1:0] THR_MODE_RESET = 2'h0;
    localparam logic [7:0] THR_VALUE_RESET = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // conversion geometry and timing
    // ----------------------------------------------------------------
    localparam int RESULT_BITS = 10;
    localparam int RESULT_PAD = 6;
    localparam logic [3:0] MSB_INDEX = 4'h9;
    localparam logic [8:0] BIT_CLOCKS = 9'h003;
    localparam logic [8:0] BITS_TOTAL = 9'h01E;
    localparam logic [8:0] MIN_SAMPLE = 9'h001;

    // clocks per conversion, indexed by the time code
    localparam logic [7:0][8:0] NORMAL_CLOCKS = {
        9'h120, 9'h060, 9'h078, 9'h090,
        9'h120, 9'h0C0, 9'h0F0, 9'h120};
    localparam logic [7:0][8:0] FAST3_CLOCKS = {
        9'h038, 9'h070, 9'h0A8, 9'h0E0,
        9'h018, 9'h030, 9'h048, 9'h060};
    localparam logic [7:0][8:0] FAST5_CLOCKS = {
        9'h048, 9'h048, 9'h048, 9'h048,
        9'h012, 9'h024, 9'h036, 9'h048};

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic run;
        logic scan;
        logic [2:0] time_code;
        logic fast_5v;
        logic fast_3v;
        logic boost;
    } sarc_mode_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_BIT = 3'b100
    } sarc_state_type;

    typedef enum logic [2:0] {
        REG_MODE,
        REG_RESULT,
        REG_RESULT_HIGH,
        REG_CHANNEL,
        REG_THR_MODE,
        REG_THR_VALUE,
        REG_STATUS,
        REG_NONE
    } sarc_reg_type;

endpackage

// >>> hdl/sarc_top.sv
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
// Contract
// - resolve each conversion MSB first, one bit at a time to the LSB.
// - after the LSB decision copy the approximation into the result.
// - the approximation register is not reachable from the bus.
// - result holds 10 bits left-justified in 16, low 6 bits read zero.
// - with threshold detection, raise done only when the compare holds.
// - without threshold detection, raise done on every finished conversion.
// - the high byte view returns the upper 8 result bits.
// - mode register is 8 bits, byte-writable, resets to zero.
// - run bit 0 stops conversion, 1 enables it.
// - scan bit 0 selects one channel, 1 scans several.
// - 5 V fast bit selects high-speed timing when set.
// - 3 V fast bit selects high-speed timing when set.
// - boost bit 0 stops the boost reference, 1 runs it; the code also runs it whenever run is 1.
// - fast mode: rewriting mode during a conversion restarts it.
// - normal timing: code gives 288/240/192/-/144/120/96 clocks.
// - fast timings: 3 V and 5 V clock counts per code.
module sarc_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // analog front end
    output logic sample_hold,
    output logic [2:0] analog_inputs_select,
    output logic [9:0] trial_code,
    output logic boost_reference_on,
    input wire logic comparator_high,
    // event
    output logic conversion_done_irq
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] aw_addr;
        logic aw_got;
        logic [7:0] w_data;
        logic w_strb;
        logic w_got;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        sarc_pkg::sarc_mode_type mode;
        logic [2:0] input_channel_select;
        logic [1:0] threshold_compare_mode;
        logic [7:0] threshold_value;
        logic [9:0] result;
        sarc_pkg::sarc_state_type state;
        logic [2:0] channel;
        logic [3:0] bit_idx;
        logic [8:0] count;
        logic [9:0] approx;
        logic cmp_meta;
        logic cmp_sync;
        logic done;
    } sarc_regs_type;

    sarc_regs_type r;
    sarc_regs_type next_r;

    function automatic sarc_pkg::sarc_reg_type decode(input logic [7:0] a);
        unique case (a)
            sarc_pkg::MODE_OFFSET: decode = sarc_pkg::REG_MODE;
            sarc_pkg::RESULT_OFFSET: decode = sarc_pkg::REG_RESULT;
            sarc_pkg::RESULT_HIGH_OFFSET: decode = sarc_pkg::REG_RESULT_HIGH;
            sarc_pkg::CHANNEL_OFFSET: decode = sarc_pkg::REG_CHANNEL;
            sarc_pkg::THR_MODE_OFFSET: decode = sarc_pkg::REG_THR_MODE;
            sarc_pkg::THR_VALUE_OFFSET: decode = sarc_pkg::REG_THR_VALUE;
            sarc_pkg::STATUS_OFFSET: decode = sarc_pkg::REG_STATUS;
            default: decode = sarc_pkg::REG_NONE;
        endcase
    endfunction

    // conversion length in clocks for the current timing selection
    function automatic logic [8:0] conv_clocks(
        input sarc_pkg::sarc_mode_type m);
        if (m.fast_5v && !m.fast_3v) begin
            conv_clocks = sarc_pkg::FAST5_CLOCKS[m.time_code];
        end else if (m.fast_3v && !m.fast_5v) begin
            conv_clocks = sarc_pkg::FAST3_CLOCKS[m.time_code];
        end else begin
            // the forbidden 11 pair falls back to normal timing
            conv_clocks = sarc_pkg::NORMAL_CLOCKS[m.time_code];
        end
    endfunction

    // whatever is left after the bit steps goes to sampling; the two
    // fastest codes cannot fit three clocks per bit and are stretched
    function automatic logic [8:0] sample_clocks(
        input sarc_pkg::sarc_mode_type m);
        logic [8:0] total;
        total = conv_clocks(m);
        if (total > sarc_pkg::BITS_TOTAL) begin
            sample_clocks = total - sarc_pkg::BITS_TOTAL;
        end else begin
            sample_clocks = sarc_pkg::MIN_SAMPLE;
        end
    endfunction

    logic wr_fire;
    logic rd_fire;
    logic mode_write;
    logic [7:0] result_high;
    logic thr_hit;
    sarc_pkg::sarc_mode_type wr_mode;

    assign wr_fire = r.aw_got && r.w_got && !r.bvalid;
    assign rd_fire = s_axi_arvalid && !r.rvalid;
    assign mode_write = wr_fire && r.w_strb &&
        decode(r.aw_addr) == sarc_pkg::REG_MODE;
    assign wr_mode = sarc_pkg::sarc_mode_type'(r.w_data);
    assign result_high = r.approx[9:2];
    // bit 6 of the compare mode picks below instead of at-or-above
    assign thr_hit = r.threshold_compare_mode[0] ?
        (result_high < r.threshold_value) :
        (result_high >= r.threshold_value);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.cmp_meta = comparator_high;
        next_r.cmp_sync = r.cmp_meta;

        // write address and data are taken in either order
        if (s_axi_awvalid && !r.aw_got) begin
            next_r.aw_got = 1'b1;
            next_r.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.w_got) begin
            next_r.w_got = 1'b1;
            next_r.w_data = s_axi_wdata[7:0];
            next_r.w_strb = s_axi_wstrb[0];
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end
        if (wr_fire) begin
            next_r.aw_got = 1'b0;
            next_r.w_got = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = sarc_pkg::RESP_OKAY;
            unique case (decode(r.aw_addr))
                sarc_pkg::REG_MODE: begin
                    if (r.w_strb) begin
                        next_r.mode = wr_mode;
                    end
                end
                sarc_pkg::REG_CHANNEL: begin
                    if (r.w_strb) begin
                        next_r.input_channel_select = r.w_data[2:0];
                    end
                end
                sarc_pkg::REG_THR_MODE: begin
                    if (r.w_strb) begin
                        next_r.threshold_compare_mode = r.w_data[7:6];
                    end
                end
                sarc_pkg::REG_THR_VALUE: begin
                    if (r.w_strb) begin
                        next_r.threshold_value = r.w_data;
                    end
                end
                // result and status ignore writes; the approximation
                // has no address at all
                sarc_pkg::REG_RESULT, sarc_pkg::REG_RESULT_HIGH,
                sarc_pkg::REG_STATUS: begin
                end
                sarc_pkg::REG_NONE: begin
                    next_r.bresp = sarc_pkg::RESP_SLVERR;
                end
            endcase
        end

        // read: one cycle from address to data
        if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
        if (rd_fire) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = sarc_pkg::RESP_OKAY;
            next_r.rdata = '0;
            unique case (decode(s_axi_araddr))
                sarc_pkg::REG_MODE: next_r.rdata[7:0] = r.mode;
                sarc_pkg::REG_RESULT: begin
                    next_r.rdata[15:0] = {r.result,
                        {sarc_pkg::RESULT_PAD{1'b0}}};
                end
                sarc_pkg::REG_RESULT_HIGH: begin
                    next_r.rdata[7:0] = r.result[9:2];
                end
                sarc_pkg::REG_CHANNEL: begin
                    next_r.rdata[2:0] = r.input_channel_select;
                end
                sarc_pkg::REG_THR_MODE: begin
                    next_r.rdata[7:6] = r.threshold_compare_mode;
                end
                sarc_pkg::REG_THR_VALUE: begin
                    next_r.rdata[7:0] = r.threshold_value;
                end
                sarc_pkg::REG_STATUS: begin
                    next_r.rdata[7:0] = {r.state != sarc_pkg::ST_IDLE,
                        r.state == sarc_pkg::ST_SAMPLE, 3'h0, r.channel};
                end
                sarc_pkg::REG_NONE: next_r.rresp = sarc_pkg::RESP_SLVERR;
            endcase
        end

        // sequencer
        unique case (r.state)
            sarc_pkg::ST_IDLE: begin
                if (r.mode.run) begin
                    next_r.state = sarc_pkg::ST_SAMPLE;
                    next_r.count = sample_clocks(r.mode);
                    next_r.channel = r.mode.scan ?
                        3'h0 : r.input_channel_select;
                    next_r.approx = '0;
                end
            end
            sarc_pkg::ST_SAMPLE: begin
                if (r.count == 9'h001) begin
                    next_r.state = sarc_pkg::ST_BIT;
                    next_r.bit_idx = sarc_pkg::MSB_INDEX;
                    next_r.count = sarc_pkg::BIT_CLOCKS;
                    next_r.approx[sarc_pkg::MSB_INDEX] = 1'b1;
                end else begin
                    next_r.count = r.count - 9'h001;
                end
            end
            sarc_pkg::ST_BIT: begin
                if (r.count == 9'h001) begin
                    // keep the trial bit only if the input is above it
                    next_r.approx[r.bit_idx] = r.cmp_sync;
                    if (r.bit_idx == 4'h0) begin
                        next_r.result = {r.approx[9:1], r.cmp_sync};
                        next_r.done = !r.threshold_compare_mode[1] ||
                            thr_hit;
                        next_r.state = sarc_pkg::ST_SAMPLE;
                        next_r.count = sample_clocks(r.mode);
                        next_r.approx = '0;
                        if (!r.mode.scan) begin
                            next_r.channel = r.input_channel_select;
                        end else if (r.channel >= r.input_channel_select) begin
                            next_r.channel = 3'h0;
                        end else begin
                            next_r.channel = r.channel + 3'h1;
                        end
                    end else begin
                        next_r.bit_idx = r.bit_idx - 4'h1;
                        next_r.approx[r.bit_idx - 4'h1] = 1'b1;
                        next_r.count = sarc_pkg::BIT_CLOCKS;
                    end
                end else begin
                    next_r.count = r.count - 9'h001;
                end
            end
        endcase

        // the threshold compare needs the finished word, so use the
        // completed approximation for the high byte on the last step
        if (r.state == sarc_pkg::ST_BIT && r.count == 9'h001 &&
            r.bit_idx == 4'h0 && r.threshold_compare_mode[1]) begin
            next_r.done = r.threshold_compare_mode[0] ?
                ({r.approx[9:2]} < r.threshold_value) :
                ({r.approx[9:2]} >= r.threshold_value);
        end

        // a rewrite in fast timing throws the conversion away
        if (mode_write && r.state != sarc_pkg::ST_IDLE && wr_mode.run &&
            (r.mode.fast_5v ^ r.mode.fast_3v)) begin
            next_r.state = sarc_pkg::ST_SAMPLE;
            next_r.count = sample_clocks(wr_mode);
            next_r.approx = '0;
            next_r.done = 1'b0;
        end

        // stop wins over everything; the result register is untouched
        if (!next_r.mode.run) begin
            next_r.state = sarc_pkg::ST_IDLE;
            next_r.approx = '0;
            next_r.done = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.mode <= sarc_pkg::MODE_RESET;
            r.input_channel_select <= sarc_pkg::CHANNEL_RESET;
            r.threshold_compare_mode <= sarc_pkg::THR_MODE_RESET;
            r.threshold_value <= sarc_pkg::THR_VALUE_RESET;
            r.state <= sarc_pkg::ST_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = !r.aw_got;
    assign s_axi_wready = !r.w_got;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rresp = r.rresp;
    assign s_axi_rdata = r.rdata;
    assign sample_hold = r.state == sarc_pkg::ST_SAMPLE;
    assign analog_inputs_select = r.channel;
    assign trial_code = r.approx;
    // the generator also comes up on its own while running
    assign boost_reference_on = r.mode.boost || r.mode.run;
    assign conversion_done_irq = r.done;

endmodule

// >>> sim/sarc_top_asserts.sv
`timescale 1ns/10ps
module sarc_top_asserts (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus read side
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    // converter
    input wire logic sample_hold,
    input wire logic [9:0] trial_code,
    input wire logic conversion_done_irq
);
    logic [7:0] rd_addr;
    logic [8:0] gap;
    logic seen;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // gap saturates so long idle stretches never wrap into a false failure
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_addr <= 8'h00;
            gap <= 9'h000;
            seen <= 1'b0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
            if (conversion_done_irq) gap <= 9'h000;
            else if (gap != 9'h1FF) gap <= gap + 9'h001;
            if (conversion_done_irq) seen <= 1'b1;
        end
    end

    property p_done_pulse;
        conversion_done_irq |=> !conversion_done_irq;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("done pulse longer than one cycle");
    property p_msb_first;
        // a stop or restart clears the code, which ends the phase early
        $fell(sample_hold) && trial_code != 10'h000 |->
            trial_code == 10'h200;
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("first trial is not the top bit alone");
    property p_second_bit;
        $fell(sample_hold) && trial_code != 10'h000 ##3
            trial_code != 10'h000 |->
            trial_code[8] && trial_code[7:0] == 8'h00;
    endproperty
    a_second_bit: assert property (p_second_bit)
        else $error("second trial is not the next bit down");
    property p_done_after_bits;
        conversion_done_irq |-> !$past(sample_hold);
    endproperty
    a_done_after_bits: assert property (p_done_after_bits)
        else $error("done without a finished bit phase");
    property p_repeat;
        conversion_done_irq |-> sample_hold;
    endproperty
    a_repeat: assert property (p_repeat)
        else $error("no new sample after done");
    property p_min_gap;
        conversion_done_irq && seen |-> gap >= 9'd30;
    endproperty
    a_min_gap: assert property (p_min_gap)
        else $error("conversions closer than 31 clocks");
    property p_result_pad;
        s_axi_rvalid && rd_addr == sarc_pkg::RESULT_OFFSET |->
            s_axi_rdata[5:0] == 6'h00 && s_axi_rdata[31:16] == 16'h0000;
    endproperty
    a_result_pad: assert property (p_result_pad)
        else $error("result word not left-justified in 16 bits");
    property p_high_byte;
        s_axi_rvalid && rd_addr == sarc_pkg::RESULT_HIGH_OFFSET |->
            s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_high_byte: assert property (p_high_byte)
        else $error("high byte view wider than 8 bits");
endmodule

bind sarc_top sarc_top_asserts u_asserts (
    .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .sample_hold(sample_hold), .trial_code(trial_code),
    .conversion_done_irq(conversion_done_irq));

// >>> sim/sarc_analog_model.sv
`timescale 1ns/10ps
module sarc_analog_model (
    // clock and setup
    input wire logic aclk,
    input wire logic slow,
    input wire logic [10:0] base,
    // converter side
    input wire logic sample_hold,
    input wire logic [2:0] analog_inputs_select,
    input wire logic [9:0] trial_code,
    output logic comparator_high
);
    // levels are in half steps and odd, so no trial ever ties
    logic [10:0] held;
    logic now_high;
    logic late;

    assign now_high = held > {trial_code, 1'b0};
    assign comparator_high = slow ? late : now_high;
    always_ff @(posedge aclk) begin
        if (sample_hold) held <= base + {2'h0, analog_inputs_select, 6'h00};
        late <= now_high;
    end
endmodule

// >>> sim/tb.sv
`timescale 1ns/10ps
module tb;
    logic aclk, aresetn, slow;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, sample_hold, boost_reference_on;
    logic comparator_high, conversion_done_irq;
    logic [2:0] analog_inputs_select;
    logic [9:0] trial_code;
    logic [10:0] base;
    logic [7:0] m;
    int fails, checked, cnt, n, k;
    int tot[18] = '{288, 240, 192, 144, 120, 96, 96, 72, 48, 24, 224,
        168, 112, 56, 72, 54, 36, 18};

    sarc_top dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .sample_hold(sample_hold),
        .analog_inputs_select(analog_inputs_select),
        .trial_code(trial_code), .boost_reference_on(boost_reference_on),
        .comparator_high(comparator_high),
        .conversion_done_irq(conversion_done_irq));
    sarc_analog_model analog (.aclk(aclk), .slow(slow), .base(base),
        .sample_hold(sample_hold), .analog_inputs_select(analog_inputs_select),
        .trial_code(trial_code), .comparator_high(comparator_high));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // ------
    // shared tasks
    // ------
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        if (fails == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic give_up();
        fails++;
        finish_test();
    endtask
    // each bus task lets an edge pass first so no strobe is set twice
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
        if (i == 100) give_up();
    endtask
    task automatic axi_read(input logic [7:0] a);
        int i;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        if (i == 100) give_up();
    endtask
    task automatic rd_chk(string what, logic [7:0] a, logic [31:0] exp);
        axi_read(a);
        check(what, exp, rd);
    endtask
    task automatic wait_done();
        for (cnt = 1; cnt < 1000; cnt++) begin
            @(posedge aclk);
            if (conversion_done_irq) break;
        end
        if (cnt == 1000) give_up();
    endtask
    task automatic wait_sample();
        logic prev;
        prev = sample_hold;
        for (cnt = 0; cnt < 1000; cnt++) begin
            @(posedge aclk);
            if (sample_hold && !prev) break;
            prev = sample_hold;
        end
        if (cnt == 1000) give_up();
    endtask
    task automatic count_done(int len);
        cnt = 0;
        repeat (len) begin
            @(posedge aclk);
            if (conversion_done_irq) cnt++;
        end
    endtask

    // ------
    // main sequence
    // ------
    initial begin
        {aresetn, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        base = 11'h2A7;
        fails = 0;
        checked = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk("mode reset", sarc_pkg::MODE_OFFSET, 32'h0);
        axi_read(8'h1C);
        check("unmapped resp", 32'(sarc_pkg::RESP_SLVERR), 32'(resp));
        axi_write(sarc_pkg::MODE_OFFSET, 32'h01);
        check("boost on", 32'h1, 32'(boost_reference_on));
        axi_write(sarc_pkg::MODE_OFFSET, 32'h00);
        check("boost off", 32'h0, 32'(boost_reference_on));
        axi_write(sarc_pkg::MODE_OFFSET, 32'h01);
        repeat (1750) @(posedge aclk); // 14 us settle
        for (n = 0; n < 18; n++) begin
            if (n < 6) m = 8'h81 | 8'((n < 3 ? n : n + 1) << 3);
            else if (n < 14) m = 8'h83 | 8'((n - 6) << 3);
            else m = 8'h85 | 8'((n - 14) << 3); // one fast bit only
            slow <= n[0];
            axi_write(sarc_pkg::MODE_OFFSET, 32'h01); // stop
            axi_write(sarc_pkg::MODE_OFFSET, {24'h0, m});
            wait_done();
            wait_done();
            check("clocks", 32'(tot[n] < 31 ? 31 : tot[n]),
                32'(cnt));
        end
        slow <= 1'b0;
        axi_write(sarc_pkg::CHANNEL_OFFSET, 32'h2);
        for (n = 0; n < 2; n++) begin
            axi_write(sarc_pkg::MODE_OFFSET, 32'h01);
            axi_write(sarc_pkg::MODE_OFFSET, n ? 32'hF1 : 32'hB1);
            for (k = 0; k < 5; k++) begin
                wait_sample();
                check("chan", n ? k % 3 : 2, 32'(analog_inputs_select));
            end
        end
        axi_write(sarc_pkg::MODE_OFFSET, 32'h01);
        axi_write(sarc_pkg::MODE_OFFSET, 32'hB1);
        wait_done();
        base <= 11'h111;
        rd_chk("result", sarc_pkg::RESULT_OFFSET, 32'h64C0);
        rd_chk("high", sarc_pkg::RESULT_HIGH_OFFSET, 32'h64);
        axi_write(sarc_pkg::RESULT_OFFSET, 32'hFFFF);
        check("ro resp", 32'(sarc_pkg::RESP_OKAY), 32'(resp));
        rd_chk("ro result", sarc_pkg::RESULT_OFFSET, 32'h64C0);
        repeat (70) @(posedge aclk);
        axi_write(sarc_pkg::MODE_OFFSET, 32'h01);
        count_done(300);
        check("done after stop", 32'h0, 32'(cnt));
        check("idle", 32'h0, 32'(sample_hold));
        rd_chk("kept", sarc_pkg::RESULT_OFFSET, 32'h64C0);
        base <= 11'h2A7;
        axi_write(sarc_pkg::THR_VALUE_OFFSET, 32'h40);
        axi_write(sarc_pkg::THR_MODE_OFFSET, 32'h80);
        axi_write(sarc_pkg::MODE_OFFSET, 32'h9D);
        count_done(200);
        check("at or above", 32'h1, 32'(cnt != 0));
        axi_write(sarc_pkg::THR_MODE_OFFSET, 32'hC0);
        count_done(200);
        check("below", 32'h0, 32'(cnt));
        axi_write(sarc_pkg::THR_MODE_OFFSET, 32'h00);
        count_done(200);
        check("no threshold", 32'h1, 32'(cnt != 0));
        axi_write(sarc_pkg::MODE_OFFSET, 32'h01);
        axi_write(sarc_pkg::MODE_OFFSET, 32'hA3);
        wait_done();
        repeat (100) @(posedge aclk);
        axi_write(sarc_pkg::MODE_OFFSET, 32'hA3); // same value
        wait_done();
        check("restart", 32'h1, 32'(cnt >= 200));
        finish_test();
    end
endmodule
